// ==== aht_consts.vh ====
// Purpose: Shared constants of the access hold and rate trim block
// Assumes: 20 MHz system clock, 32.768 kHz oscillator sampled as a pin
// Notes: Definitions only
`ifndef AHT_CONSTS_VH
`define AHT_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AHT_ADDR_SEC 4'h0
`define AHT_ADDR_TRIM 4'h7
`define AHT_ADDR_CTRL1 4'he
`define AHT_ADDR_CTRL2 4'hf
`define AHT_PTR_AFTER_STOP 4'hf

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define AHT_TRIM_PERIOD_BIT 7
`define AHT_C2_VDSL_BIT 7
`define AHT_C2_XST_BIT 5
`define AHT_C2_PON_BIT 4
`define AHT_C2_CLEN1_BIT 3
`define AHT_C2_CTFG_BIT 2
`define AHT_CT_OFF 3'h0
`define AHT_READ_LOCKED 8'hff
`define AHT_TRIM_NEG_BASE 8'h80
`define AHT_TRIM_POS_BASE 8'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AHT_TRIM_RST 8'h00
`define AHT_CTRL1_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AHT_OSC_HZ 32768
`define AHT_DIV_LEN 16'h8000
`define AHT_DIV_HALF 16'h4000
`define AHT_PERIOD_SHORT 6'h14
`define AHT_PERIOD_LONG 6'h3c
`define AHT_TIMEOUT_MIN_MS 500
`define AHT_TIMEOUT_MAX_MS 1000
`define AHT_TIMEOUT_MID_MS 750
`define AHT_TIMEOUT_TICKS (`AHT_OSC_HZ * `AHT_TIMEOUT_MID_MS / 1000)

`endif

// ==== aht_bus_cond.v ====
// Purpose: Finds start and stop conditions on the two-wire bus pins
// Assumes: SCL and SDA are asynchronous to clock_in
// Notes: Pulses are one clock long
`timescale 1ns/1ps
`default_nettype none

module aht_bus_cond (
  input wire clock_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output wire start_out,
  output wire stop_out
);

  reg scl_s1_reg;
  reg scl_s2_reg;
  reg scl_s3_reg;
  reg sda_s1_reg;
  reg sda_s2_reg;
  reg sda_s3_reg;

  // Idle bus is high, so the chain resets high to avoid a false edge
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  assign start_out = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_out = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

endmodule // aht_bus_cond

`default_nettype wire

// ==== aht_core.v ====
// Purpose: Seconds carry hold during bus access, access timeout, rate trim
// Assumes: Byte framing lives outside and uses the wr/rd byte ports
// Notes: Time base is the sampled 32.768 kHz oscillator pin
`timescale 1ns/1ps
`default_nettype none
`include "aht_consts.vh"

// What this block does
// - From start until transaction end, freeze visible counters and hold carries.
// - A held carry is applied soon after the stop, well inside 61 us.
// - Transaction open 0.5 to 1.0 s is ended as if a stop arrived.
// - Repeated start does not restart the timeout; it runs from first start.
// - After forced release, writes get no acknowledge and reads return FFh.
// - The 32.768 kHz reference clock is driven out from power-on.
// - Trim changes one second's length once every 20 or 60 seconds.
// - Trim value is a 7-bit field, negatives stored as 128 minus magnitude.
// - Trim bits five to one all zero means no correction.
// - Positive code slows the count by its distance from 01h.
// - Negative code speeds the count by its distance from 80h.
// - Trim never alters the reference clock output.
// - Periodic select 011 in control 1 gives a 1 Hz pulse on interrupt A.
// - The 1 Hz pulse shows one altered period per trim interval.
// - While power-on flag is set, trim and listed control bits are zero.
// - Every stop, forced or real, loads the address pointer with Fh.
// - Periodic select picks pulse mode or level mode on interrupt A.
module aht_core #(
  parameter TIMEOUT_TICKS = `AHT_TIMEOUT_TICKS
) (
  input wire clock_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire osc_in,
  input wire wr_stb_in,
  input wire [3:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire rd_stb_in,
  input wire [3:0] rd_addr_in,
  output reg [7:0] rd_data_out,
  output wire ack_ok_out,
  output reg ptr_load_out,
  output reg [3:0] ptr_load_addr_out,
  output wire counters_hold_out,
  output reg sec_tick_out,
  output reg ref_clock_out,
  output reg ref_clock_out_alt,
  output reg irq_out_a_n_out,
  output reg irq_out_b_n_out
);

  localparam [31:0] TIMEOUT_LAST = TIMEOUT_TICKS - 1;

  // Ticks added or removed at the adjustment second, two per trim step
  function [7:0] trim_ticks;
    input [6:0] code;
    reg [7:0] steps;
    begin
      steps = 8'h00;
      if (code[6])
        steps = `AHT_TRIM_NEG_BASE - {1'b0, code};
      else
        steps = {1'b0, code} - `AHT_TRIM_POS_BASE;
      trim_ticks = {steps[6:0], 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------
  // Oscillator sampling
  // ----------------------------------------------------------------
  reg osc_s1_reg;
  reg osc_s2_reg;
  reg osc_s3_reg;
  wire osc_tick;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      ref_clock_out <= 1'b0;
      ref_clock_out_alt <= 1'b0;
    end else begin
      osc_s1_reg <= osc_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      ref_clock_out <= osc_s2_reg;
      ref_clock_out_alt <= osc_s2_reg;
    end
  end

  assign osc_tick = osc_s2_reg & ~osc_s3_reg;

  // ----------------------------------------------------------------
  // Transaction tracking and timeout
  // ----------------------------------------------------------------
  wire start_evt;
  wire stop_evt;
  reg open_reg;
  reg lock_reg;
  reg [15:0] to_cnt_reg;
  wire first_start;
  wire timed_out;

  aht_bus_cond u_bus_cond (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_out(start_evt),
    .stop_out(stop_evt)
  );

  assign first_start = start_evt & ~open_reg;
  assign timed_out = open_reg & osc_tick & (to_cnt_reg == TIMEOUT_LAST[15:0]);

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      open_reg <= 1'b0;
      lock_reg <= 1'b0;
      to_cnt_reg <= 16'h0000;
      ptr_load_out <= 1'b0;
      ptr_load_addr_out <= `AHT_PTR_AFTER_STOP;
    end else begin
      if (timed_out)
        open_reg <= 1'b0;
      else if (start_evt)
        open_reg <= 1'b1;
      else if (stop_evt)
        open_reg <= 1'b0;
      if (timed_out)
        lock_reg <= 1'b1;
      else if (first_start)
        lock_reg <= 1'b0;
      // Repeated starts leave the count alone
      if (first_start | stop_evt)
        to_cnt_reg <= 16'h0000;
      else if (open_reg & osc_tick)
        to_cnt_reg <= to_cnt_reg + 16'h0001;
      ptr_load_out <= stop_evt | timed_out;
      ptr_load_addr_out <= `AHT_PTR_AFTER_STOP;
    end
  end

  assign counters_hold_out = open_reg;
  assign ack_ok_out = ~lock_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] trim_reg;
  reg [7:0] ctrl1_reg;
  reg pon_reg;
  reg xst_reg;
  reg vdsl_reg;
  reg clen1_reg;
  reg ctfg_reg;
  reg [7:0] sec_reg;
  wire wr_ok;
  wire ctfg_set;
  wire apply;

  assign wr_ok = wr_stb_in & ~lock_reg;
  assign ctfg_set = apply & ctrl1_reg[2];

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      trim_reg <= `AHT_TRIM_RST;
      ctrl1_reg <= `AHT_CTRL1_RST;
      pon_reg <= 1'b1;
      xst_reg <= 1'b0;
      vdsl_reg <= 1'b0;
      clen1_reg <= 1'b0;
      ctfg_reg <= 1'b0;
    end else begin
      if (pon_reg) begin
        trim_reg <= `AHT_TRIM_RST;
        ctrl1_reg <= `AHT_CTRL1_RST;
        vdsl_reg <= 1'b0;
        clen1_reg <= 1'b0;
        ctfg_reg <= 1'b0;
      end else begin
        if (wr_ok && wr_addr_in == `AHT_ADDR_TRIM)
          trim_reg <= wr_data_in;
        if (wr_ok && wr_addr_in == `AHT_ADDR_CTRL1)
          ctrl1_reg <= wr_data_in;
        if (wr_ok && wr_addr_in == `AHT_ADDR_CTRL2) begin
          vdsl_reg <= wr_data_in[`AHT_C2_VDSL_BIT];
          clen1_reg <= wr_data_in[`AHT_C2_CLEN1_BIT];
        end
        // Set wins over a software clear in the same cycle
        if (ctfg_set)
          ctfg_reg <= 1'b1;
        else if (wr_ok && wr_addr_in == `AHT_ADDR_CTRL2 && !wr_data_in[`AHT_C2_CTFG_BIT])
          ctfg_reg <= 1'b0;
      end
      if (wr_ok && wr_addr_in == `AHT_ADDR_CTRL2) begin
        xst_reg <= wr_data_in[`AHT_C2_XST_BIT];
        if (!wr_data_in[`AHT_C2_PON_BIT])
          pon_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trimmed seconds divider
  // ----------------------------------------------------------------
  reg [15:0] div_reg;
  reg [5:0] phase_reg;
  reg pend_reg;
  wire [5:0] period;
  wire trim_on;
  wire [7:0] adj;
  reg [15:0] sec_len;
  wire wrap;

  assign period = trim_reg[`AHT_TRIM_PERIOD_BIT] ? `AHT_PERIOD_LONG : `AHT_PERIOD_SHORT;
  assign trim_on = |trim_reg[5:1];
  assign adj = trim_ticks(trim_reg[6:0]);

  always @* begin
    sec_len = `AHT_DIV_LEN;
    if (trim_on && phase_reg == 6'h00) begin
      if (trim_reg[6])
        sec_len = `AHT_DIV_LEN - {8'h00, adj};
      else
        sec_len = `AHT_DIV_LEN + {8'h00, adj};
    end
  end

  assign wrap = osc_tick & (div_reg >= sec_len - 16'h0001);
  assign apply = pend_reg & ~open_reg;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= 16'h0000;
      phase_reg <= 6'h00;
      pend_reg <= 1'b0;
      sec_reg <= 8'h00;
      sec_tick_out <= 1'b0;
    end else begin
      // Divider never stops, so a held access costs no time
      if (wrap)
        div_reg <= 16'h0000;
      else if (osc_tick)
        div_reg <= div_reg + 16'h0001;
      if (wrap)
        phase_reg <= (phase_reg >= period - 6'h01) ? 6'h00 : phase_reg + 6'h01;
      pend_reg <= (pend_reg & ~apply) | wrap;
      sec_tick_out <= apply;
      if (apply) begin
        if (sec_reg[3:0] == 4'h9) begin
          sec_reg[3:0] <= 4'h0;
          sec_reg[7:4] <= (sec_reg[7:4] == 4'h5) ? 4'h0 : sec_reg[7:4] + 4'h1;
        end else begin
          sec_reg[3:0] <= sec_reg[3:0] + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port and interrupt pins
  // ----------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (rd_addr_in)
      `AHT_ADDR_SEC: rd_mux = sec_reg;
      `AHT_ADDR_TRIM: rd_mux = trim_reg;
      `AHT_ADDR_CTRL1: rd_mux = ctrl1_reg;
      `AHT_ADDR_CTRL2: rd_mux = {vdsl_reg, 1'b0, xst_reg, pon_reg, clen1_reg, ctfg_reg, 2'b00};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
      irq_out_a_n_out <= 1'b1;
      irq_out_b_n_out <= 1'b1;
    end else begin
      if (rd_stb_in)
        rd_data_out <= lock_reg ? `AHT_READ_LOCKED : rd_mux;
      if (ctrl1_reg[2:0] == `AHT_CT_OFF)
        irq_out_a_n_out <= 1'b1;
      else if (ctrl1_reg[2])
        irq_out_a_n_out <= ~ctfg_reg;
      else
        irq_out_a_n_out <= (div_reg >= `AHT_DIV_HALF);
      // Alarm logic is not part of this block
      irq_out_b_n_out <= 1'b1;
    end
  end

endmodule // aht_core

`default_nettype wire

// ==== aht_core_assertions.sv ====
// Purpose: Port checks for the access hold block
// Assumes: One clock domain, async active-high reset
// Notes: Bound to aht_core after the module
`timescale 1ns/1ps
`default_nettype none
module aht_core_chk #(
  parameter TIMEOUT_TICKS = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic osc_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rd_data_out,
  input wire logic ack_ok_out,
  input wire logic ptr_load_out,
  input wire logic [3:0] ptr_load_addr_out,
  input wire logic counters_hold_out,
  input wire logic ref_clock_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  int tick_cnt_reg;
  logic osc_prev_reg;
  // ------------------------------------------------------------
  // Oscillator ticks counted while the hold stands
  // ------------------------------------------------------------
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_reg <= 0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_in;
      if (!counters_hold_out) begin
        tick_cnt_reg <= 0;
      end else if (osc_in && !osc_prev_reg) begin
        tick_cnt_reg <= tick_cnt_reg + 1;
      end
    end
  end
  a_hold_on_start: assert property (
    scl_in && $fell(sda_in) |-> ##[3:5] counters_hold_out) else $error("no hold after start");
  a_stop_release: assert property (
    scl_in && $rose(sda_in) |-> ##[3:5] !counters_hold_out) else $error("hold after stop");
  a_stop_ptr_load: assert property (
    scl_in && $rose(sda_in) |-> ##[3:5] ptr_load_out) else $error("no pointer load");
  a_ptr_load_addr: assert property (
    ptr_load_out |-> ptr_load_addr_out == 4'hf) else $error("pointer load address");
  a_timeout_bound: assert property (
    tick_cnt_reg <= TIMEOUT_TICKS + 1) else $error("hold outlived timeout");
  a_end_as_stop: assert property (
    $fell(counters_hold_out) |-> ptr_load_out) else $error("release without pointer load");
  a_locked_read: assert property (
    rd_stb_in && !ack_ok_out |=> rd_data_out == 8'hff) else $error("locked read not ff");
  a_unlock_start: assert property (
    $rose(ack_ok_out) |-> ##[0:1] counters_hold_out) else $error("unlock without start");
  a_ref_rise: assert property (
    $rose(osc_in) |-> ##[2:4] ref_clock_out) else $error("ref clock missed rise");
  a_ref_fall: assert property (
    $fell(osc_in) |-> ##[2:4] !ref_clock_out) else $error("ref clock missed fall");
endmodule // aht_core_chk
bind aht_core aht_core_chk #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) u_chk (.clock_in, .rst_in,
  .scl_in, .sda_in, .osc_in, .rd_stb_in, .rd_data_out, .ack_ok_out, .ptr_load_out,
  .ptr_load_addr_out, .counters_hold_out, .ref_clock_out);
`default_nettype wire

// ==== aht_host_model.sv ====
// Purpose: Bus master model making start, repeated start and stop
// Assumes: Pulled-up pins, so an idle line reads high
// Notes: Byte framing is not modelled
`timescale 1ns/1ps
`default_nettype none
module aht_host_model (
  input wire logic clock_in,
  output logic scl_out,
  output logic sda_out
);
  time stop_t = 0;
  time start_t = 0;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    repeat (4) @(posedge clock_in);
    #1;
    scl_out = c;
    sda_out = d;
  endtask
  // A new start waits until 61 us have passed since the last stop
  task automatic start;
    while ($time - stop_t < 61000) @(posedge clock_in);
    step(1'b1, 1'b0);
    start_t = $time;
    step(1'b0, 1'b0);
  endtask
  task automatic rstart;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    stop_t = $time;
  endtask
endmodule // aht_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the access hold block
// Assumes: Oscillator pin runs free at 400 ns period
// Notes: Reads queue their expected byte; a watcher compares
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0, rst_in = 1'b1, osc_in = 1'b0, wr_stb_in = 1'b0, rd_stb_in = 1'b0;
  logic [3:0] wr_addr_in = 4'h0, rd_addr_in = 4'h0, ptr_load_addr_out;
  logic [7:0] wr_data_in = 8'h00, rd_data_out, trim;
  logic scl_in, sda_in, ack_ok_out, ptr_load_out, counters_hold_out, sec_tick_out;
  logic ref_clock_out, ref_clock_out_alt, irq_out_a_n_out, irq_out_b_n_out, rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int num_errors = 0, checks_done = 0, seed = 32'hae75, n, el, carries = 0;
  always #25 clock_in = ~clock_in;
  initial #7 forever #200 osc_in = ~osc_in;
  aht_host_model u_host (.clock_in, .scl_out(scl_in), .sda_out(sda_in));
  aht_core #(.TIMEOUT_TICKS(8)) u_dut (.clock_in, .rst_in, .scl_in, .sda_in, .osc_in,
    .wr_stb_in, .wr_addr_in, .wr_data_in, .rd_stb_in, .rd_addr_in, .rd_data_out,
    .ack_ok_out, .ptr_load_out, .ptr_load_addr_out, .counters_hold_out, .sec_tick_out,
    .ref_clock_out, .ref_clock_out_alt, .irq_out_a_n_out, .irq_out_b_n_out);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    wr_stb_in = 1'b1;
    wr_addr_in = a;
    wr_data_in = d;
    @(posedge clock_in);
    #1;
    wr_stb_in = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    #1;
    rd_stb_in = 1'b1;
    rd_addr_in = a;
    exp_q.push_back(e);
    @(posedge clock_in);
    #1;
    rd_stb_in = 1'b0;
  endtask
  // Bounded wait; running out counts as a failure
  task automatic wait_hold(input logic lvl);
    n = 0;
    while (counters_hold_out !== lvl && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  always @(posedge clock_in) begin
    if (rd_seen) begin
      chk("read data", exp_q.pop_front(), rd_data_out);
    end
    rd_seen = rd_stb_in;
  end
  // Far less than one second of oscillator ticks passes, so no carry may show
  always @(posedge clock_in) begin
    if (!rst_in && sec_tick_out !== 1'b0) begin
      carries++;
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_in);
    #1 rst_in = 1'b0;
    chk("irq a idle", 8'h01, {7'h00, irq_out_a_n_out});
    chk("irq b idle", 8'h01, {7'h00, irq_out_b_n_out});
    rd(4'h7, 8'h00);
    rd(4'he, 8'h00);
    rd(4'hf, 8'h10);
    wr(4'h7, 8'h7f);
    rd(4'h7, 8'h00);
    wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
    wr(4'hf, 8'hb8);
    rd(4'hf, 8'ha8);
    rd(4'h0, 8'h00);
    wr(4'h7, 8'h7f);
    rd(4'h7, 8'h7f);
    repeat (4) begin
      trim = 8'($random(seed));
      wr(4'h7, trim);
      rd(4'h7, trim);
    end
    wr(4'he, 8'h03);
    rd(4'he, 8'h03);
    repeat (3) @(posedge clock_in);
    #1;
    chk("irq a pulse", 8'h00, {7'h00, irq_out_a_n_out});
    wr(4'he, 8'h04);
    repeat (3) @(posedge clock_in);
    #1;
    chk("irq a level", 8'h01, {7'h00, irq_out_a_n_out});
    @(posedge osc_in);
    repeat (3) @(posedge clock_in);
    #1;
    chk("ref clock rise", 8'h03, {6'h00, ref_clock_out, ref_clock_out_alt});
    @(negedge osc_in);
    repeat (3) @(posedge clock_in);
    #1;
    chk("ref clock fall", 8'h00, {6'h00, ref_clock_out, ref_clock_out_alt});
    u_host.start();
    wait_hold(1'b1);
    repeat (30) @(posedge clock_in);
    u_host.rstart();
    wait_hold(1'b0);
    el = int'(($time - u_host.start_t) / 50);
    chk("timeout early", 8'h01, {7'h00, el >= 56});
    chk("timeout restarted", 8'h01, {7'h00, el < 100});
    chk("ack locked", 8'h00, {7'h00, ack_ok_out});
    wr(4'h7, 8'h00);
    rd(4'h7, 8'hff);
    u_host.stop();
    u_host.start();
    wait_hold(1'b1);
    chk("ack unlocked", 8'h01, {7'h00, ack_ok_out});
    rd(4'h7, trim);
    u_host.stop();
    wait_hold(1'b0);
    repeat (4) @(posedge clock_in);
    chk("seconds carries", 8'h00, carries[7:0]);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
